// [hw/rmcg_pkg.sv]
package rmcg_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam int NUM_UNITS = 10;

  // Register byte offsets
  localparam logic [11:0] RUN_GATE_OFFSET = 12'h104;
  localparam logic [11:0] SLEEP_GATE_OFFSET = 12'h114;
  localparam logic [11:0] DEEP_GATE_OFFSET = 12'h124;
  localparam logic [11:0] CLOCK_CONFIG_OFFSET = 12'h1F0;
  localparam logic [11:0] GATE_STATUS_OFFSET = 12'h1F4;
  localparam logic [11:0] FAULT_STATUS_OFFSET = 12'h1F8;

  // Reset values
  localparam logic [31:0] GATE_RESET = 32'h0000_0000;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // Writable gate bits; every other bit is reserved and reads zero
  localparam logic [31:0] GATE_IMPL_MASK = 32'h0707_1013;

  // Gate bit positions
  localparam int SERIAL_PORT_A_BIT = 0;
  localparam int SERIAL_PORT_B_BIT = 1;
  localparam int SYNC_SERIAL_BIT = 4;
  localparam int I2C_UNIT_BIT = 12;
  localparam int GP_TIMER_A_BIT = 16;
  localparam int GP_TIMER_B_BIT = 17;
  localparam int GP_TIMER_C_BIT = 18;
  localparam int COMPARATOR_A_BIT = 24;
  localparam int COMPARATOR_B_BIT = 25;
  localparam int COMPARATOR_C_BIT = 26;

  // Unit index to gate bit position
  localparam int UNIT_BIT [NUM_UNITS] = '{
    SERIAL_PORT_A_BIT, SERIAL_PORT_B_BIT, SYNC_SERIAL_BIT, I2C_UNIT_BIT,
    GP_TIMER_A_BIT, GP_TIMER_B_BIT, GP_TIMER_C_BIT,
    COMPARATOR_A_BIT, COMPARATOR_B_BIT, COMPARATOR_C_BIT
  };

  // Clock configuration field
  localparam int AUTO_GATING_SELECT_BIT = 0;
  localparam logic [31:0] CONFIG_IMPL_MASK = 32'h0000_0001;

  typedef enum logic [1:0] {
    RMCG_MODE_RUN = 2'b00,
    RMCG_MODE_SLEEP = 2'b01,
    RMCG_MODE_DEEP = 2'b10
  } rmcg_mode_t;

endpackage

// [hw/rmcg_clock_gate_cell.sv]
`timescale 1ns/1ps
// Latch opens only while the clock is low, so the enable can never cut
// or stretch a high phase already under way.
module rmcg_clock_gate_cell (
  input wire logic clock,
  input wire logic enable,
  output logic gatedClock
);

  logic enLatch;

  always_latch begin
    if (!clock) begin
      enLatch <= enable;
    end
  end

  assign gatedClock = clock & enLatch;

endmodule

// [hw/rmcg_access_guard.sv]
`timescale 1ns/1ps
module rmcg_access_guard #(
  parameter int NUM_UNITS = rmcg_pkg::NUM_UNITS
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [NUM_UNITS-1:0] periphSel,
  input wire logic periphRd,
  input wire logic periphWr,
  input wire logic [NUM_UNITS-1:0] unitEnable,
  output logic accessGrant_r,
  output logic busFault_r,
  output logic [NUM_UNITS-1:0] faultUnits_r
);

  logic accessGrant_nxt;
  logic busFault_nxt;
  logic [NUM_UNITS-1:0] faultUnits_nxt;
  logic [NUM_UNITS-1:0] blocked;
  logic request;

  always_comb begin
    request = periphRd | periphWr;
    blocked = periphSel & ~unitEnable;
    // One disabled target is enough to fail the whole access
    busFault_nxt = request && (blocked != '0);
    accessGrant_nxt = request && (periphSel != '0) && (blocked == '0);
    faultUnits_nxt = request ? blocked : '0;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      accessGrant_r <= 1'b0;
      busFault_r <= 1'b0;
      faultUnits_r <= '0;
    end else begin
      accessGrant_r <= accessGrant_nxt;
      busFault_r <= busFault_nxt;
      faultUnits_r <= faultUnits_nxt;
    end
  end

endmodule

// [hw/rmcg_run_mode_clock_gate.sv]
`timescale 1ns/1ps
module rmcg_run_mode_clock_gate #(
  parameter int NUM_UNITS = rmcg_pkg::NUM_UNITS
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [rmcg_pkg::ADDR_W-1:0] regAddr,
  input wire logic [rmcg_pkg::DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [rmcg_pkg::DATA_W-1:0] regRdata_r,
  input wire logic sleepReq,
  input wire logic deepSleepReq,
  input wire logic [NUM_UNITS-1:0] periphSel,
  input wire logic periphRd,
  input wire logic periphWr,
  output logic accessGrant_r,
  output logic busFault_r,
  output logic serial_port_a_clock_enable,
  output logic serial_port_b_clock_enable,
  output logic sync_serial_clock_enable,
  output logic i2c_unit_clock_enable,
  output logic gp_timer_a_clock_enable,
  output logic gp_timer_b_clock_enable,
  output logic gp_timer_c_clock_enable,
  output logic comparator_a_clock_enable,
  output logic comparator_b_clock_enable,
  output logic comparator_c_clock_enable,
  output logic [NUM_UNITS-1:0] unitClock
);

  // Unit order inside the enable vector; must match UNIT_BIT
  localparam int UNIT_PORT_A = 0;
  localparam int UNIT_PORT_B = 1;
  localparam int UNIT_SYNC = 2;
  localparam int UNIT_I2C = 3;
  localparam int UNIT_TIMER_A = 4;
  localparam int UNIT_TIMER_B = 5;
  localparam int UNIT_TIMER_C = 6;
  localparam int UNIT_CMP_A = 7;
  localparam int UNIT_CMP_B = 8;
  localparam int UNIT_CMP_C = 9;

  logic [31:0] runGate_r;
  logic [31:0] runGate_nxt;
  logic [31:0] sleepGate_r;
  logic [31:0] sleepGate_nxt;
  logic [31:0] deepGate_r;
  logic [31:0] deepGate_nxt;
  logic [31:0] clockConfig_r;
  logic [31:0] clockConfig_nxt;
  logic [NUM_UNITS-1:0] faultSticky_r;
  logic [NUM_UNITS-1:0] faultSticky_nxt;
  logic [NUM_UNITS-1:0] effEnable_r;
  logic [NUM_UNITS-1:0] effEnable_nxt;
  logic [31:0] regRdata_nxt;
  logic [31:0] activeGate;
  logic [31:0] effWord;
  logic [NUM_UNITS-1:0] faultUnits;
  logic [NUM_UNITS-1:0] w1cMask;
  logic runWrSel;
  logic sleepWrSel;
  logic deepWrSel;
  logic configWrSel;
  logic faultWrSel;
  logic autoGating;
  rmcg_pkg::rmcg_mode_t mode_r;
  rmcg_pkg::rmcg_mode_t mode_nxt;

  // Write decode; writes to unmapped offsets are dropped
  always_comb begin
    runWrSel = regWr && (regAddr == rmcg_pkg::RUN_GATE_OFFSET);
    sleepWrSel = regWr && (regAddr == rmcg_pkg::SLEEP_GATE_OFFSET);
    deepWrSel = regWr && (regAddr == rmcg_pkg::DEEP_GATE_OFFSET);
    configWrSel = regWr && (regAddr == rmcg_pkg::CLOCK_CONFIG_OFFSET);
    faultWrSel = regWr && (regAddr == rmcg_pkg::FAULT_STATUS_OFFSET);
  end

  // Run gate register; reserved bits are masked so they stay zero
  always_comb begin
    runGate_nxt = runGate_r;
    if (runWrSel) begin
      runGate_nxt = regWdata & rmcg_pkg::GATE_IMPL_MASK;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      runGate_r <= rmcg_pkg::GATE_RESET;
    end else begin
      runGate_r <= runGate_nxt;
    end
  end

  // Low-power gate sets; consulted only while auto gating is on
  always_comb begin
    sleepGate_nxt = sleepGate_r;
    deepGate_nxt = deepGate_r;
    if (sleepWrSel) begin
      sleepGate_nxt = regWdata & rmcg_pkg::GATE_IMPL_MASK;
    end
    if (deepWrSel) begin
      deepGate_nxt = regWdata & rmcg_pkg::GATE_IMPL_MASK;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sleepGate_r <= rmcg_pkg::GATE_RESET;
      deepGate_r <= rmcg_pkg::GATE_RESET;
    end else begin
      sleepGate_r <= sleepGate_nxt;
      deepGate_r <= deepGate_nxt;
    end
  end

  // Clock configuration: only the auto gating select bit is kept
  always_comb begin
    clockConfig_nxt = clockConfig_r;
    if (configWrSel) begin
      clockConfig_nxt = regWdata & rmcg_pkg::CONFIG_IMPL_MASK;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      clockConfig_r <= rmcg_pkg::CONFIG_RESET;
    end else begin
      clockConfig_r <= clockConfig_nxt;
    end
  end

  // Sticky fault record per unit, written with ones to clear
  always_comb begin
    w1cMask = '0;
    if (faultWrSel) begin
      w1cMask = regWdata[NUM_UNITS-1:0];
    end
    // A new fault wins over a clear in the same cycle
    faultSticky_nxt = (faultSticky_r & ~w1cMask) | faultUnits;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      faultSticky_r <= '0;
    end else begin
      faultSticky_r <= faultSticky_nxt;
    end
  end

  // Power mode follows the core's sleep requests; deep sleep wins.
  // The requests come from the same clock, so no synchroniser is needed.
  always_comb begin
    if (deepSleepReq) begin
      mode_nxt = rmcg_pkg::RMCG_MODE_DEEP;
    end else if (sleepReq) begin
      mode_nxt = rmcg_pkg::RMCG_MODE_SLEEP;
    end else begin
      mode_nxt = rmcg_pkg::RMCG_MODE_RUN;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mode_r <= rmcg_pkg::RMCG_MODE_RUN;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // Governing gate set; without auto gating the run set always holds
  always_comb begin
    autoGating = clockConfig_r[rmcg_pkg::AUTO_GATING_SELECT_BIT];
    case (mode_r)
      rmcg_pkg::RMCG_MODE_RUN: begin
        activeGate = runGate_r;
      end
      rmcg_pkg::RMCG_MODE_SLEEP: begin
        activeGate = autoGating ? sleepGate_r : runGate_r;
      end
      rmcg_pkg::RMCG_MODE_DEEP: begin
        activeGate = autoGating ? deepGate_r : runGate_r;
      end
      default: begin
        activeGate = runGate_r;
      end
    endcase
    for (int i = 0; i < NUM_UNITS; i++) begin
      effEnable_nxt[i] = activeGate[rmcg_pkg::UNIT_BIT[i]];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      effEnable_r <= '0;
    end else begin
      effEnable_r <= effEnable_nxt;
    end
  end

  // Effective enables laid back out at their gate bit positions
  always_comb begin
    effWord = '0;
    for (int i = 0; i < NUM_UNITS; i++) begin
      effWord[rmcg_pkg::UNIT_BIT[i]] = effEnable_r[i];
    end
  end

  // Read path: one cycle latency, unmapped reads return zero.
  // Data drops back to zero after one cycle so no stale word lingers.
  always_comb begin
    regRdata_nxt = rmcg_pkg::READ_ZERO;
    if (regRd) begin
      case (regAddr)
        rmcg_pkg::RUN_GATE_OFFSET: begin
          regRdata_nxt = runGate_r;
        end
        rmcg_pkg::SLEEP_GATE_OFFSET: begin
          regRdata_nxt = sleepGate_r;
        end
        rmcg_pkg::DEEP_GATE_OFFSET: begin
          regRdata_nxt = deepGate_r;
        end
        rmcg_pkg::CLOCK_CONFIG_OFFSET: begin
          regRdata_nxt = clockConfig_r;
        end
        rmcg_pkg::GATE_STATUS_OFFSET: begin
          regRdata_nxt = effWord;
        end
        rmcg_pkg::FAULT_STATUS_OFFSET: begin
          regRdata_nxt = {{(32-NUM_UNITS){1'b0}}, faultSticky_r};
        end
        default: begin
          regRdata_nxt = rmcg_pkg::READ_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      regRdata_r <= rmcg_pkg::READ_ZERO;
    end else begin
      regRdata_r <= regRdata_nxt;
    end
  end

  // Named enables straight from the effective-enable flops.
  // All of them move on one edge, so units start and stop together.
  assign serial_port_a_clock_enable = effEnable_r[UNIT_PORT_A];
  assign serial_port_b_clock_enable = effEnable_r[UNIT_PORT_B];
  assign sync_serial_clock_enable = effEnable_r[UNIT_SYNC];
  assign i2c_unit_clock_enable = effEnable_r[UNIT_I2C];
  assign gp_timer_a_clock_enable = effEnable_r[UNIT_TIMER_A];
  assign gp_timer_b_clock_enable = effEnable_r[UNIT_TIMER_B];
  assign gp_timer_c_clock_enable = effEnable_r[UNIT_TIMER_C];
  assign comparator_a_clock_enable = effEnable_r[UNIT_CMP_A];
  assign comparator_b_clock_enable = effEnable_r[UNIT_CMP_B];
  assign comparator_c_clock_enable = effEnable_r[UNIT_CMP_C];

  // Gated unit clocks; these come from gate cells, not flops.
  // A unit switched off mid-cycle keeps its high phase whole.
  for (genvar g = 0; g < NUM_UNITS; g++) begin : gen_gate
    rmcg_clock_gate_cell u_gate (
      .clock(clock),
      .enable(effEnable_r[g]),
      .gatedClock(unitClock[g])
    );
  end

  // Grant and fault are registered so the answer leaves on a clean edge
  rmcg_access_guard #(
    .NUM_UNITS(NUM_UNITS)
  ) u_guard (
    .clock(clock),
    .nrst(nrst),
    .periphSel(periphSel),
    .periphRd(periphRd),
    .periphWr(periphWr),
    .unitEnable(effEnable_r),
    .accessGrant_r(accessGrant_r),
    .busFault_r(busFault_r),
    .faultUnits_r(faultUnits)
  );

endmodule

// [test/rmcg_run_mode_clock_gate_monitor.sv]
`timescale 1ns/1ps
module rmcg_run_mode_clock_gate_monitor #(
  parameter int NUM_UNITS = rmcg_pkg::NUM_UNITS
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [rmcg_pkg::ADDR_W-1:0] regAddr,
  input wire logic [rmcg_pkg::DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [rmcg_pkg::DATA_W-1:0] regRdata_r,
  input wire logic sleepReq,
  input wire logic deepSleepReq,
  input wire logic [NUM_UNITS-1:0] periphSel,
  input wire logic periphRd,
  input wire logic periphWr,
  input wire logic accessGrant_r,
  input wire logic busFault_r,
  input wire logic serial_port_a_clock_enable,
  input wire logic serial_port_b_clock_enable,
  input wire logic sync_serial_clock_enable,
  input wire logic i2c_unit_clock_enable,
  input wire logic gp_timer_a_clock_enable,
  input wire logic gp_timer_b_clock_enable,
  input wire logic gp_timer_c_clock_enable,
  input wire logic comparator_a_clock_enable,
  input wire logic comparator_b_clock_enable,
  input wire logic comparator_c_clock_enable,
  input wire logic [NUM_UNITS-1:0] unitClock
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  localparam logic [31:0] MSK = rmcg_pkg::GATE_IMPL_MASK;
  logic [9:0] en;
  logic [9:0] gw;
  logic acc;
  logic runWr;
  assign en = {comparator_c_clock_enable, comparator_b_clock_enable,
    comparator_a_clock_enable, gp_timer_c_clock_enable,
    gp_timer_b_clock_enable, gp_timer_a_clock_enable, i2c_unit_clock_enable,
    sync_serial_clock_enable, serial_port_b_clock_enable,
    serial_port_a_clock_enable};
  assign gw = {regWdata[26:24], regWdata[18:16], regWdata[12], regWdata[4],
    regWdata[1:0]};
  assign acc = periphRd | periphWr;
  assign runWr = regWr && regAddr == rmcg_pkg::RUN_GATE_OFFSET;
  sequence s_wr; runWr; endsequence
  sequence s_rd; regRd && regAddr == rmcg_pkg::RUN_GATE_OFFSET; endsequence
  property p_fault;
    acc && |(periphSel & ~en) |=> busFault_r && !accessGrant_r;
  endproperty
  a_fault: assert property (p_fault) else $error("fault missing");
  property p_grant;
    acc && periphSel != '0 && (periphSel & ~en) == '0
      |=> accessGrant_r && !busFault_r;
  endproperty
  a_grant: assert property (p_grant) else $error("grant missing");
  property p_quiet; !acc |=> !accessGrant_r && !busFault_r; endproperty
  a_quiet: assert property (p_quiet) else $error("stray answer");
  property p_idle; !regRd |=> regRdata_r == '0; endproperty
  a_idle: assert property (p_idle) else $error("read data held");
  property p_resv; s_rd |=> (regRdata_r & ~MSK) == '0; endproperty
  a_resv: assert property (p_resv) else $error("reserved bit set");
  property p_back;
    s_wr ##1 s_rd |=> regRdata_r == ($past(regWdata, 2) & MSK);
  endproperty
  a_back: assert property (p_back) else $error("readback wrong");
  property p_map;
    runWr && !sleepReq && !deepSleepReq |=> ##1 en == $past(gw, 2);
  endproperty
  a_map: assert property (p_map) else $error("enable map");
  // Sampled at the falling edge so the high phase just ended is seen
  property p_gclk;
    @(negedge clock) disable iff (!nrst)
      en == $past(en) |-> unitClock == en;
  endproperty
  a_gclk: assert property (p_gclk) else $error("gated clock");
endmodule

bind rmcg_run_mode_clock_gate rmcg_run_mode_clock_gate_monitor #(
  .NUM_UNITS(NUM_UNITS)
) i_mon (
  .clock(clock), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata_r(regRdata_r),
  .sleepReq(sleepReq), .deepSleepReq(deepSleepReq),
  .periphSel(periphSel), .periphRd(periphRd), .periphWr(periphWr),
  .accessGrant_r(accessGrant_r), .busFault_r(busFault_r),
  .serial_port_a_clock_enable(serial_port_a_clock_enable),
  .serial_port_b_clock_enable(serial_port_b_clock_enable),
  .sync_serial_clock_enable(sync_serial_clock_enable),
  .i2c_unit_clock_enable(i2c_unit_clock_enable),
  .gp_timer_a_clock_enable(gp_timer_a_clock_enable),
  .gp_timer_b_clock_enable(gp_timer_b_clock_enable),
  .gp_timer_c_clock_enable(gp_timer_c_clock_enable),
  .comparator_a_clock_enable(comparator_a_clock_enable),
  .comparator_b_clock_enable(comparator_b_clock_enable),
  .comparator_c_clock_enable(comparator_c_clock_enable),
  .unitClock(unitClock)
);

// [test/rmcg_run_mode_clock_gate_tb.sv]
`timescale 1ns/1ps
module rmcg_run_mode_clock_gate_tb;
  logic clock, nrst, regWr, regRd, sleepReq, deepSleepReq;
  logic periphRd, periphWr, accessGrant_r, busFault_r;
  logic [11:0] regAddr;
  logic [31:0] regWdata, regRdata_r, got;
  logic [9:0] periphSel, en, unitClock;
  int fail_count = 0;
  int num_checks = 0;
  logic [31:0] rw [4] = '{32'hFFFF_FFFF, 32'h0505_0011, 32'h0202_1002,
    32'hF8F8_EFEC};
  logic [31:0] rr [4] = '{32'h0707_1013, 32'h0505_0011, 32'h0202_1002,
    32'h0000_0000};
  logic [9:0] re [4] = '{10'h3FF, 10'h2D5, 10'h12A, 10'h000};
  rmcg_run_mode_clock_gate i_dut (.clock(clock), .nrst(nrst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata_r(regRdata_r), .sleepReq(sleepReq),
    .deepSleepReq(deepSleepReq), .periphSel(periphSel),
    .periphRd(periphRd), .periphWr(periphWr),
    .accessGrant_r(accessGrant_r), .busFault_r(busFault_r),
    .serial_port_a_clock_enable(en[0]), .serial_port_b_clock_enable(en[1]),
    .sync_serial_clock_enable(en[2]), .i2c_unit_clock_enable(en[3]),
    .gp_timer_a_clock_enable(en[4]), .gp_timer_b_clock_enable(en[5]),
    .gp_timer_c_clock_enable(en[6]), .comparator_a_clock_enable(en[7]),
    .comparator_b_clock_enable(en[8]), .comparator_c_clock_enable(en[9]),
    .unitClock(unitClock));
  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWr <= 1'h0;
  endtask
  task rd(input logic [11:0] a);
    @(posedge clock);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'h0;
    @(negedge clock);
    got = regRdata_r;
  endtask
  // Drives a peripheral read or write and expects grant or fault
  task acc(input logic [9:0] s, input logic r, input logic g);
    @(posedge clock);
    periphRd <= r;
    periphWr <= ~r;
    periphSel <= s;
    @(posedge clock);
    {periphRd, periphWr} <= 2'h0;
    periphSel <= 10'h000;
    @(negedge clock);
    chk("grant", {31'h0, g}, {31'h0, accessGrant_r});
    chk("fault", {31'h0, ~g}, {31'h0, busFault_r});
  endtask
  // Enables lag the cause by two edges, so wait past both
  task settle;
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask
  task results;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #40000;
    fail_count++;
    results;
  end
  initial begin
    {nrst, regWr, regRd, sleepReq, deepSleepReq, periphRd, periphWr} = 7'h0;
    regAddr = 12'h000;
    regWdata = 32'h0000_0000;
    periphSel = 10'h000;
    repeat (4) @(posedge clock);
    nrst <= 1'h1;
    rd(12'h104);
    chk("reset value", 32'h0, got);
    chk("reset enables", 32'h0, {22'h0, en});
    acc(10'h008, 1'h1, 1'h0);
    $display("reset value test done");
    for (int i = 0; i < 4; i++) begin
      wr(12'h104, rw[i]);
      settle();
      chk("enables", {22'h0, re[i]}, {22'h0, en});
      rd(12'h104);
      chk("readback", rr[i], got);
    end
    $display("table rows done");
    @(posedge clock);
    regWr <= 1'h1;
    regAddr <= 12'h104;
    regWdata <= 32'h0000_1000;
    @(posedge clock);
    regWr <= 1'h0;
    regRd <= 1'h1;
    @(posedge clock);
    regRd <= 1'h0;
    @(negedge clock);
    chk("back to back", 32'h0000_1000, regRdata_r);
    acc(10'h008, 1'h0, 1'h1);
    acc(10'h009, 1'h0, 1'h0);
    rd(12'h100);
    chk("unmapped", 32'h0, got);
    rd(12'h1F4);
    chk("gate status", 32'h0000_1000, got);
    rd(12'h1F8);
    chk("fault record", 32'h0000_0009, got);
    wr(12'h1F8, 32'h0000_0009);
    rd(12'h1F8);
    chk("fault cleared", 32'h0, got);
    $display("access test done");
    @(posedge clock);
    sleepReq <= 1'h1;
    settle();
    chk("sleep no auto", 32'h8, {22'h0, en});
    wr(12'h114, 32'h0000_0001);
    wr(12'h124, 32'h0100_0000);
    wr(12'h1F0, 32'h0000_0001);
    settle();
    chk("sleep set", 32'h1, {22'h0, en});
    @(posedge clock);
    deepSleepReq <= 1'h1;
    settle();
    chk("deep set", 32'h80, {22'h0, en});
    @(posedge clock);
    {sleepReq, deepSleepReq} <= 2'h0;
    settle();
    chk("run again", 32'h8, {22'h0, en});
    $display("mode test done");
    @(posedge clock);
    nrst <= 1'h0;
    @(posedge clock);
    nrst <= 1'h1;
    rd(12'h104);
    chk("mid reset", 32'h0, got);
    chk("mid reset enables", 32'h0, {22'h0, en});
    $display("reset test done");
    results;
  end
endmodule
